// file: hw/esp_pkg.sv
package esp_pkg;
   localparam int ADDR_W = 2;
   // Register offsets
   localparam logic [1:0] OFS_DATA = 2'h0;
   localparam logic [1:0] OFS_CTRL = 2'h1;
   localparam logic [1:0] OFS_PWR = 2'h2;
   localparam logic [1:0] OFS_RELOAD = 2'h3;
   // serial_control_reg fields
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_MP = 5;
   localparam int CTL_REN = 4;
   localparam int CTL_TX9 = 3;
   localparam int CTL_RX9 = 2;
   localparam int CTL_TXF = 1;
   localparam int CTL_RXF = 0;
   // power_control_reg fields
   localparam int PWR_DBL = 7;
   localparam int PWR_RX_T2 = 5;
   localparam int PWR_TX_T2 = 4;
   localparam int PWR_X2 = 0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   // Mode encodings
   localparam logic [1:0] MODE_SHIFT = 2'b00;
   localparam logic [1:0] MODE_10BIT = 2'b01;
   localparam logic [1:0] MODE_11FIX = 2'b10;
   localparam logic [1:0] MODE_11VAR = 2'b11;
   // Cycle, tick and bit counts
   localparam logic [3:0] M0_DIV_12 = 4'hc;
   localparam logic [3:0] M0_DIV_6 = 4'h6;
   localparam logic [3:0] T1_PRESCALE = 4'hc;
   localparam logic [6:0] M2_N_12 = 7'h40;
   localparam logic [6:0] M2_N_6 = 7'h20;
   localparam logic [2:0] HALF_TICKS_12 = 3'h1;
   localparam logic [2:0] HALF_TICKS_6 = 3'h2;
   localparam logic [3:0] SMP_A = 4'h7;
   localparam logic [3:0] SMP_B = 4'h8;
   localparam logic [3:0] SMP_C = 4'h9;
   localparam logic [3:0] ROLL16 = 4'hf;
   localparam logic [3:0] RX_LAST_BIT = 4'h9;
   localparam logic [3:0] TX_BITS_M1 = 4'ha;
   localparam logic [3:0] TX_BITS_M23 = 4'hb;
   localparam logic [2:0] M0_LAST_BIT = 3'h7;

   typedef struct packed {
      logic [1:0] mode;
      logic dbl;
      logic x2;
   } esp_cfg_t;
endpackage

// file: hw/esp_baud.sv
`timescale 1ns/1ps
`default_nettype none
module esp_baud
   import esp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire esp_cfg_t cfg_i,
   input wire logic use_t2_i,
   input wire logic t1_ovf_i,
   input wire logic t2_ovf_i,
   output logic tick_o
);
   logic [2:0] pend_q;
   logic [2:0] pend_d;
   logic [5:0] div_q;
   logic [5:0] m2_per;
   logic [2:0] half;
   logic ovf;
   logic tick_d;

   // Timer-fed modes: half sample ticks per overflow, so 6-clock doubling keeps exact rate
   always_comb begin
      m2_per = 6'((cfg_i.x2 ? M2_N_6 : M2_N_12) >> (4 + int'(cfg_i.dbl)));
      half = (cfg_i.x2 ? HALF_TICKS_6 : HALF_TICKS_12) << cfg_i.dbl;
      ovf = use_t2_i ? t2_ovf_i : t1_ovf_i;
      pend_d = pend_q + (ovf ? half : 3'h0);
      tick_d = 1'b0;
      if (pend_d >= 3'h2) begin
         tick_d = 1'b1;
         pend_d = pend_d - 3'h2;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_q <= 3'h0;
         div_q <= 6'h00;
         tick_o <= 1'b0;
      end else if (cfg_i.mode == MODE_11FIX) begin
         pend_q <= 3'h0;
         div_q <= (div_q >= m2_per - 6'h01) ? 6'h00 : div_q + 6'h01;
         tick_o <= (div_q >= m2_per - 6'h01);
      end else begin
         div_q <= 6'h00;
         pend_q <= pend_d;
         tick_o <= tick_d;
      end
   end
endmodule
`default_nettype wire

// file: hw/esp_top.sv
`timescale 1ns/1ps
`default_nettype none
module esp_top
   import esp_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic rxd_i,
   output logic rxd_o,
   output logic rxd_oe_o,
   output logic txd_o,
   input wire logic t2_ovf_i
);
   typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} esp_m0_st_t;
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} esp_tx_st_t;
   typedef enum logic {RX_IDLE, RX_BITS} esp_rx_st_t;

   function automatic logic maj3(input logic a, input logic b, input logic c);
      maj3 = (a & b) | (a & c) | (b & c);
   endfunction

   logic [1:0] mode_q;
   logic mp_q, ren_q, tx9_q, rx9_q, txf_q, rxf_q;
   logic dbl_q, rx_t2_q, tx_t2_q, x2_q;
   logic [7:0] reload_q, rx_buf_q;
   esp_cfg_t cfg;
   logic wr_data, wr_ctrl, wr_pwr;
   logic txf_set, rxf_set, rx9_load, rx9_val;
   // Timer 1
   logic [3:0] pre_q;
   logic [7:0] t1_q;
   logic t1_ovf;
   // Mode 0
   esp_m0_st_t m0_st_q;
   logic [3:0] m0_cnt_q, m0_div;
   logic [2:0] m0_bit_q;
   logic [7:0] m0_sh_q;
   logic m0_end, m0_done;
   // Async transmit
   esp_tx_st_t tx_st_q;
   logic tx_tick;
   logic [3:0] tx16_q, tx_bit_q;
   logic [10:0] tx_sh_q;
   logic tx_roll, tx_done;
   // Async receive
   esp_rx_st_t rx_st_q;
   logic rx_tick, rx_prev_q, rx_bit, rx_last, rx_accept;
   logic [3:0] rx16_q, rx_idx_q;
   logic [1:0] rx_smp_q;
   logic [8:0] rx_sh_q;

   assign cfg = '{mode: mode_q, dbl: dbl_q, x2: x2_q};
   assign wr_data = reg_wr_i && reg_addr_i == OFS_DATA;
   assign wr_ctrl = reg_wr_i && reg_addr_i == OFS_CTRL;
   assign wr_pwr = reg_wr_i && reg_addr_i == OFS_PWR;

   // Register writes
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= MODE_SHIFT;
         {mp_q, ren_q, tx9_q} <= 3'h0;
         {dbl_q, rx_t2_q, tx_t2_q, x2_q} <= 4'h0;
         reload_q <= RST_BYTE;
      end else begin
         if (wr_ctrl) begin
            mode_q <= reg_wdata_i[CTL_MODE_LO+:2];
            mp_q <= reg_wdata_i[CTL_MP];
            ren_q <= reg_wdata_i[CTL_REN];
            tx9_q <= reg_wdata_i[CTL_TX9];
         end
         if (wr_pwr) begin
            dbl_q <= reg_wdata_i[PWR_DBL];
            rx_t2_q <= reg_wdata_i[PWR_RX_T2];
            tx_t2_q <= reg_wdata_i[PWR_TX_T2];
            x2_q <= reg_wdata_i[PWR_X2];
         end
         if (reg_wr_i && reg_addr_i == OFS_RELOAD) begin
            reload_q <= reg_wdata_i;
         end
      end
   end

   // Done flags: hardware set beats a same-cycle software clear
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         {txf_q, rxf_q, rx9_q} <= 3'h0;
      end else begin
         if (txf_set) begin
            txf_q <= 1'b1;
         end else if (wr_ctrl && !reg_wdata_i[CTL_TXF]) begin
            txf_q <= 1'b0;
         end
         if (rxf_set) begin
            rxf_q <= 1'b1;
         end else if (wr_ctrl && !reg_wdata_i[CTL_RXF]) begin
            rxf_q <= 1'b0;
         end
         if (rx9_load) begin
            rx9_q <= rx9_val;
         end else if (wr_ctrl) begin
            rx9_q <= reg_wdata_i[CTL_RX9];
         end
      end
   end

   // Read data one cycle after the strobe; held otherwise
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            OFS_DATA: reg_rdata_o <= rx_buf_q;
            OFS_CTRL: reg_rdata_o <= {mode_q, mp_q, ren_q, tx9_q, rx9_q, txf_q, rxf_q};
            OFS_PWR: reg_rdata_o <= {dbl_q, 1'b0, rx_t2_q, tx_t2_q, 3'h0, x2_q};
            OFS_RELOAD: reg_rdata_o <= reload_q;
         endcase
      end
   end

   // Timer 1, 8-bit auto-reload, one count per 12 clocks
   assign t1_ovf = pre_q == T1_PRESCALE - 4'h1 && t1_q == 8'hff;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pre_q <= 4'h0;
         t1_q <= 8'h00;
      end else begin
         pre_q <= (pre_q == T1_PRESCALE - 4'h1) ? 4'h0 : pre_q + 4'h1;
         if (t1_ovf) begin
            t1_q <= reload_q;
         end else if (pre_q == T1_PRESCALE - 4'h1) begin
            t1_q <= t1_q + 8'h01;
         end
      end
   end

   // Separate generators so each direction may pick its own timer
   esp_baud u_tx_baud (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .cfg_i(cfg),
      .use_t2_i(tx_t2_q),
      .t1_ovf_i(t1_ovf),
      .t2_ovf_i(t2_ovf_i),
      .tick_o(tx_tick)
   );
   esp_baud u_rx_baud (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .cfg_i(cfg),
      .use_t2_i(rx_t2_q),
      .t1_ovf_i(t1_ovf),
      .t2_ovf_i(t2_ovf_i),
      .tick_o(rx_tick)
   );

   // Mode 0 shift engine
   assign m0_div = x2_q ? M0_DIV_6 : M0_DIV_12;
   assign m0_end = m0_cnt_q == m0_div - 4'h1;
   assign m0_done = m0_st_q != M0_IDLE && m0_end && m0_bit_q == M0_LAST_BIT;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         m0_st_q <= M0_IDLE;
         m0_cnt_q <= 4'h0;
         m0_bit_q <= 3'h0;
         m0_sh_q <= 8'h00;
      end else if (mode_q != MODE_SHIFT) begin
         m0_st_q <= M0_IDLE;
      end else if (wr_data) begin
         m0_st_q <= M0_TX;
         m0_sh_q <= reg_wdata_i;
         m0_cnt_q <= 4'h0;
         m0_bit_q <= 3'h0;
      end else if (m0_st_q == M0_IDLE) begin
         m0_cnt_q <= 4'h0;
         m0_bit_q <= 3'h0;
         if (!rxf_q && ren_q) begin
            m0_st_q <= M0_RX;
         end
      end else begin
         m0_cnt_q <= m0_end ? 4'h0 : m0_cnt_q + 4'h1;
         // Sample on the rising shift clock, mid bit
         if (m0_st_q == M0_RX && m0_cnt_q == (m0_div >> 1)) begin
            m0_sh_q <= {rxd_i, m0_sh_q[7:1]};
         end
         if (m0_end) begin
            m0_bit_q <= m0_bit_q + 3'h1;
            if (m0_st_q == M0_TX) begin
               m0_sh_q <= {1'b1, m0_sh_q[7:1]};
            end
            if (m0_bit_q == M0_LAST_BIT) begin
               m0_st_q <= M0_IDLE;
            end
         end
      end
   end

   // Async transmit, bit times locked to the free divide-by-16
   assign tx_roll = tx_tick && tx16_q == ROLL16;
   assign tx_done = tx_st_q == TX_SEND && tx_roll
                    && tx_bit_q == ((mode_q == MODE_10BIT) ? TX_BITS_M1 : TX_BITS_M23) - 4'h1;
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_st_q <= TX_IDLE;
         tx16_q <= 4'h0;
         tx_bit_q <= 4'h0;
         tx_sh_q <= 11'h7ff;
      end else begin
         if (tx_tick) begin
            tx16_q <= tx16_q + 4'h1;
         end
         if (wr_data && mode_q != MODE_SHIFT) begin
            tx_st_q <= TX_WAIT;
            // Mode 1 puts the stop bit where modes 2 and 3 put the ninth bit
            tx_sh_q <= {1'b1, (mode_q == MODE_10BIT) ? 1'b1 : tx9_q, reg_wdata_i, 1'b0};
            tx_bit_q <= 4'h0;
         end else if (mode_q == MODE_SHIFT) begin
            tx_st_q <= TX_IDLE;
         end else if (tx_st_q == TX_WAIT && tx_roll) begin
            tx_st_q <= TX_SEND;
         end else if (tx_st_q == TX_SEND && tx_roll) begin
            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            if (tx_done) begin
               tx_st_q <= TX_IDLE;
            end
         end
      end
   end

   // Async receive with 16x majority sampling
   assign rx_bit = maj3(rx_smp_q[1], rx_smp_q[0], rxd_i);
   assign rx_last = rx_st_q == RX_BITS && rx_tick && rx16_q == SMP_C && rx_idx_q == RX_LAST_BIT;
   // Same test serves the mode 1 stop bit and the mode 2/3 ninth bit
   assign rx_accept = rx_last && !rxf_q && (!mp_q || rx_bit);
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_st_q <= RX_IDLE;
         rx_prev_q <= 1'b1;
         rx16_q <= 4'h0;
         rx_idx_q <= 4'h0;
         rx_smp_q <= 2'h3;
         rx_sh_q <= 9'h1ff;
      end else if (mode_q == MODE_SHIFT) begin
         rx_st_q <= RX_IDLE;
         rx_prev_q <= 1'b1;
      end else if (rx_tick) begin
         rx_prev_q <= rxd_i;
         if (rx_st_q == RX_IDLE) begin
            if (ren_q && rx_prev_q && !rxd_i) begin
               rx_st_q <= RX_BITS;
               rx16_q <= 4'h0;
               rx_idx_q <= 4'h0;
               rx_sh_q <= 9'h1ff;
            end
         end else begin
            rx16_q <= rx16_q + 4'h1;
            if (rx16_q == SMP_A || rx16_q == SMP_B) begin
               rx_smp_q <= {rx_smp_q[0], rxd_i};
            end
            if (rx16_q == SMP_C) begin
               rx_idx_q <= rx_idx_q + 4'h1;
               if ((rx_idx_q == 4'h0 && rx_bit) || rx_idx_q == RX_LAST_BIT) begin
                  rx_st_q <= RX_IDLE;
               end else if (rx_idx_q != 4'h0) begin
                  rx_sh_q <= {rx_bit, rx_sh_q[8:1]};
               end
            end
         end
      end
   end

   // Receive buffer only changes on an accepted frame or a finished mode 0 reception
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_buf_q <= RST_BYTE;
      end else if (rx_accept) begin
         rx_buf_q <= rx_sh_q[8:1];
      end else if (m0_done && m0_st_q == M0_RX) begin
         rx_buf_q <= m0_sh_q;
      end
   end

   assign txf_set = tx_done || (m0_done && m0_st_q == M0_TX);
   assign rxf_set = rx_accept || (m0_done && m0_st_q == M0_RX);
   assign rx9_load = rx_accept;
   assign rx9_val = rx_bit;

   // Pins; mode 0 shift clock idles high
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         txd_o <= 1'b1;
         rxd_o <= 1'b1;
         rxd_oe_o <= 1'b0;
      end else if (mode_q == MODE_SHIFT) begin
         txd_o <= m0_st_q == M0_IDLE || m0_cnt_q >= (m0_div >> 1);
         rxd_o <= m0_sh_q[0];
         rxd_oe_o <= m0_st_q == M0_TX;
      end else begin
         txd_o <= tx_st_q == TX_SEND ? tx_sh_q[0] : 1'b1;
         rxd_o <= 1'b1;
         rxd_oe_o <= 1'b0;
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   AST_TXF_SET: assert property (tx_done |=> txf_q)
      else $error("tx done did not set tx_done_flag");
   AST_RXF_HOLD: assert property (rxf_q && !(wr_ctrl && !reg_wdata_i[CTL_RXF]) |=> rxf_q)
      else $error("rx_done_flag dropped without a clear");
   AST_RX_DROP: assert property (rx_last && rxf_q |=> $stable(rx_buf_q))
      else $error("unread buffer overwritten");
   AST_MP_FILTER: assert property (rx_last && mp_q && !rx_bit && !rxf_q |=> !rxf_q)
      else $error("filtered frame raised rx_done_flag");
   AST_M0_RX_START: assert property (mode_q == MODE_SHIFT && m0_st_q == M0_IDLE && !rxf_q && ren_q
                                     && !wr_data && !wr_ctrl |=> m0_st_q == M0_RX)
      else $error("mode 0 reception did not start");
   AST_WR_STARTS: assert property (wr_data && mode_q != MODE_SHIFT |=> tx_st_q == TX_WAIT)
      else $error("data write did not start transmit");
   AST_NO_RX_OFF: assert property (!ren_q && rx_st_q == RX_IDLE |=> rx_st_q == RX_IDLE)
      else $error("reception started while disabled");
   AST_M0_DRIVE: assert property (mode_q == MODE_SHIFT && $past(mode_q) == MODE_SHIFT
                                  && $past(m0_st_q) == M0_TX |-> rxd_oe_o)
      else $error("mode 0 transmit not driving data pin");
   AST_T1_RELOAD: assert property (t1_ovf |=> t1_q == $past(reload_q))
      else $error("timer 1 did not reload");

   COV_TX: cover property (tx_done);
   COV_RX_OK: cover property (rx_accept);
   COV_M0_RX: cover property (m0_done && m0_st_q == M0_RX);
endmodule
`default_nettype wire

// file: tb/esp_partner.sv
`timescale 1ns/1ps
`default_nettype none
module esp_partner (
   input wire logic clk_i,
   input wire logic txd_i,
   input wire logic line_i,
   output logic line_o
);
   logic [7:0] m0_sh = 8'h00;
   logic m0_on = 1'b0;
   logic m0_first = 1'b0;
   logic as_q = 1'b1;
   int cyc = 0;
   always @(posedge clk_i) cyc <= cyc + 1;
   // Shift slave owns the line only while armed, else the async sender's level
   assign line_o = m0_on ? m0_sh[0] : as_q;
   // Ninth slot carries address/data mark, or the stop bit in 10-bit frames
   task automatic send(input int bp, input logic [7:0] d, input logic b9);
      logic [10:0] f;
      f = {1'b1, b9, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge clk_i);
         as_q <= f[i];
         repeat (bp - 1) @(posedge clk_i);
      end
   endtask
   // Samples at bit centres; stop sampled one slot after the ninth
   task automatic recv(input int bp, output logic [7:0] d, output logic b9, output logic st);
      @(negedge txd_i);
      repeat (bp / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++) begin
         repeat (bp) @(posedge clk_i);
         if (i < 8) d[i] = txd_i;
         else if (i == 8) b9 = txd_i;
         else st = txd_i;
      end
   endtask
   task automatic m0_cap(output logic [7:0] d, output int per);
      int c0;
      for (int i = 0; i < 8; i++) begin
         @(posedge txd_i);
         if (i == 1) per = cyc - c0;
         c0 = cyc;
         d[i] = line_i;
      end
   endtask
   task automatic m0_load(input logic [7:0] d);
      m0_sh = d;
      m0_first = 1'b1;
      m0_on = 1'b1;
   endtask
   task automatic m0_stop();
      m0_on = 1'b0;
   endtask
   // Next bit goes out at the clock's falling edge, clear of the sample point
   always @(negedge txd_i) begin
      if (m0_on) begin
         if (m0_first) m0_first = 1'b0;
         else m0_sh = m0_sh >> 1;
      end
   end
endmodule
`default_nettype wire

// file: tb/test_enhanced_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_enhanced_serial_port;
   import esp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic t2_ovf = 1'b0;
   logic [7:0] rdata;
   logic rxd_o, rxd_oe, txd, p_line, line;
   int failures = 0;
   int total_checks = 0;
   int cyc = 0;
   logic m_rxf = 1'b0;
   logic m_rx9 = 1'b0;
   logic [7:0] m_buf = 8'h00;
   always #12.5 sys_clk = ~sys_clk;
   assign line = rxd_oe ? rxd_o : p_line;
   esp_top dut (.sys_clk_i(sys_clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata), .rxd_i(line), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe), .txd_o(txd),
      .t2_ovf_i(t2_ovf));
   esp_partner p (.clk_i(sys_clk), .txd_i(txd), .line_i(line), .line_o(p_line));
   task automatic test_done();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Timer 2 overflow every 4 clocks; ceiling well above the longest run
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      t2_ovf <= (cyc % 4 == 3);
      if (cyc == 60000) begin
         failures = failures + 1;
         test_done();
      end
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [1:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(negedge sys_clk);
      d = rdata;
   endtask
   // Model of acceptance: buffer loads only with flag clear and filter passing
   task automatic expect_rx(input logic [7:0] d, input logic n9, input logic mp);
      logic [7:0] v;
      if (!m_rxf && (!mp || n9)) begin
         m_rxf = 1'b1;
         m_rx9 = n9;
         m_buf = d;
      end
      rreg(OFS_CTRL, v);
      chk("rx_done", 8'(m_rxf), 8'(v[CTL_RXF]));
      chk("rx_ninth", 8'(m_rx9), 8'(v[CTL_RX9]));
      rreg(OFS_DATA, v);
      chk("rx_buf", m_buf, v);
   endtask
   initial begin
      logic [1:0] md;
      logic [7:0] pw, d, g, x, v;
      logic n9, x9, g9, gs;
      int bp, per;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      void'($urandom(32'hc5e06a0b));
      rreg(OFS_CTRL, v);
      chk("ctrl_rst", 8'h00, v);
      rreg(OFS_PWR, v);
      chk("pwr_rst", 8'h00, v);
      for (int k = 0; k < 4; k++) begin
         case (k)
            0: begin md = MODE_11FIX; pw = 8'h00; bp = 64; end
            1: begin md = MODE_11FIX; pw = 8'h81; bp = 16; end
            2: begin md = MODE_10BIT; pw = 8'h80; bp = 192; end
            default: begin md = MODE_11VAR; pw = 8'h30; bp = 128; end
         endcase
         wreg(OFS_RELOAD, 8'hff);
         wreg(OFS_PWR, pw);
         rreg(OFS_PWR, v);
         chk("pwr", pw, v);
         n9 = 1'($urandom);
         d = 8'($urandom);
         x = 8'($urandom);
         x9 = (md == MODE_10BIT) ? 1'b1 : 1'($urandom);
         wreg(OFS_CTRL, {md, 1'b0, 1'b1, n9, 3'b000});
         // The control write clears both flags and the received ninth bit
         m_rxf = 1'b0;
         m_rx9 = 1'b0;
         // Transmit and receive overlap, transmit held until the next divide-by-16 rollover
         fork
            p.recv(bp, g, g9, gs);
            wreg(OFS_DATA, d);
            p.send(bp, x, x9);
         join
         // Capture ends mid stop bit in 11-bit frames, where the done flag follows half a bit later
         repeat (bp) @(posedge sys_clk);
         chk("tx_data", d, g);
         chk("tx_ninth", (md == MODE_10BIT) ? 8'h01 : 8'(n9), 8'(g9));
         chk("tx_stop", 8'h01, 8'(gs));
         rreg(OFS_CTRL, v);
         chk("tx_done", 8'h01, 8'(v[CTL_TXF]));
         expect_rx(x, x9, 1'b0);
         wreg(OFS_CTRL, {md, 1'b1, 1'b1, n9, 3'b000});
         m_rxf = 1'b0;
         m_rx9 = 1'b0;
         // Rejected mark (or broken stop), accepted, then overrun while unread
         for (int j = 0; j < 3; j++) begin
            x = 8'($urandom);
            x9 = (j != 0);
            p.send(bp, x, x9);
            expect_rx(x, x9, 1'b1);
         end
      end
      wreg(OFS_CTRL, 8'h00);
      m_rxf = 1'b0;
      for (int k = 0; k < 2; k++) begin
         wreg(OFS_PWR, 8'(k));
         d = 8'($urandom);
         fork
            p.m0_cap(g, per);
            wreg(OFS_DATA, d);
         join
         chk("m0_tx", d, g);
         chk("m0_period", k ? 8'd6 : 8'd12, 8'(per));
         // Last bit still has half a period to run
         repeat (12) @(posedge sys_clk);
         rreg(OFS_CTRL, v);
         chk("m0_tx_done", 8'h01, 8'(v[CTL_TXF]));
         wreg(OFS_CTRL, 8'h00);
      end
      x = 8'($urandom);
      p.m0_load(x);
      wreg(OFS_CTRL, 8'h30);
      v = 8'h00;
      for (int i = 0; i < 60 && v[CTL_RXF] !== 1'b1; i++) rreg(OFS_CTRL, v);
      p.m0_stop();
      chk("m0_rx_done", 8'h01, 8'(v[CTL_RXF]));
      rreg(OFS_DATA, v);
      chk("m0_rx", x, v);
      test_done();
   end
endmodule
`default_nettype wire
